// ===== hw/cws_defines.vh
// register map, field positions, reset values and timing for the
// standard bus wake-up and transceiver status block.
// assumes a 125 MHz system clock and byte-addressed AXI4-Lite access.
`ifndef CWS_DEFINES_VH
`define CWS_DEFINES_VH

// register indexes; byte address is four times the index
`define CWS_IDX_MODE_CTRL 8'h20
`define CWS_IDX_XCVR_COND 8'h22
`define CWS_IDX_WAKE_EVT 8'h23
`define CWS_IDX_WAKE_CFG 8'h24

// mode control fields
`define CWS_CTRL_RSVD_BIT 7
`define CWS_CTRL_FD_BIT 6
`define CWS_CTRL_VALID_BIT 5
`define CWS_CTRL_SELW_BIT 4
`define CWS_CTRL_RESET 8'h00
`define CWS_CTRL_WMASK 8'hF3

// transceiver condition fields
`define CWS_COND_ACTIVE_BIT 7
`define CWS_COND_PNERR_BIT 6
`define CWS_COND_PNCFG_BIT 5
`define CWS_COND_OSC_BIT 4
`define CWS_COND_SILENT_BIT 3
`define CWS_COND_SUPLOW_BIT 1
`define CWS_COND_TXTO_BIT 0

// wake event and wake configuration fields
`define CWS_EVT_WAKE_BIT 0
`define CWS_CFG_WAKE_EN_BIT 0
`define CWS_CFG_RESET 8'h00

// transceiver mode select codes
`define CWS_SEL_OFFLINE 2'h0
`define CWS_SEL_ACT_UV 2'h1
`define CWS_SEL_ACT_NOUV 2'h2
`define CWS_SEL_LISTEN 2'h3

// transceiver state reported on o_xcvr_state
`define CWS_XS_OFFLINE 2'h0
`define CWS_XS_OFF_BIAS 2'h1
`define CWS_XS_ACTIVE 2'h2
`define CWS_XS_LISTEN 2'h3

// chip operating mode on i_chip_mode
`define CWS_CHIP_NORMAL 2'h0
`define CWS_CHIP_STANDBY 2'h1
`define CWS_CHIP_SLEEP 2'h2
`define CWS_CHIP_RESET 2'h3

// AXI responses
`define CWS_RESP_OKAY 2'h0
`define CWS_RESP_SLVERR 2'h2

// timing, times in ns
`define CWS_CLK_NS 24'h000008
`define CWS_DOM_NS 24'h0003E8
`define CWS_REC_NS 24'h0003E8
`define CWS_WAKE_TO_NS 24'h0F4240
`define CWS_SILENCE_NS 24'h0F4240
// least times round up, longest times round down; all sized to the counters
`define CWS_DOM_CYC ((`CWS_DOM_NS + `CWS_CLK_NS - 24'h000001) / `CWS_CLK_NS)
`define CWS_REC_CYC ((`CWS_REC_NS + `CWS_CLK_NS - 24'h000001) / `CWS_CLK_NS)
`define CWS_WAKE_TO_CYC (`CWS_WAKE_TO_NS / `CWS_CLK_NS)
`define CWS_SILENCE_CYC (`CWS_SILENCE_NS / `CWS_CLK_NS)

`endif

// ===== hw/cws_wake_status.v
// standard bus wake-up filter, mode control and transceiver condition
// registers for a CAN transceiver, reached over AXI4-Lite.
// assumes bus receive level and analog flags arrive asynchronously and
// the chip mode comes from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "cws_defines.vh"

module cws_wake_status #(
	parameter PN_BUILD = 1,
	parameter [23:0] WAKE_TO_CYC = `CWS_WAKE_TO_CYC,
	parameter [23:0] SILENCE_CYC = `CWS_SILENCE_CYC
) (
	// clock and reset
	input wire i_clock,
	input wire i_resetn,
	// axi4-lite write address and data
	input wire [31:0] i_s_axi_awaddr,
	input wire [2:0] i_s_axi_awprot,
	input wire i_s_axi_awvalid,
	output wire o_s_axi_awready,
	input wire [31:0] i_s_axi_wdata,
	input wire [3:0] i_s_axi_wstrb,
	input wire i_s_axi_wvalid,
	output wire o_s_axi_wready,
	// axi4-lite write response
	output wire [1:0] o_s_axi_bresp,
	output wire o_s_axi_bvalid,
	input wire i_s_axi_bready,
	// axi4-lite read
	input wire [31:0] i_s_axi_araddr,
	input wire [2:0] i_s_axi_arprot,
	input wire i_s_axi_arvalid,
	output wire o_s_axi_arready,
	output wire [31:0] o_s_axi_rdata,
	output wire [1:0] o_s_axi_rresp,
	output wire o_s_axi_rvalid,
	input wire i_s_axi_rready,
	// bus and microcontroller pins, asynchronous
	input wire i_bus_rx,
	input wire i_txd,
	output wire o_rxd,
	output wire o_tx_enable,
	output wire o_bias_on,
	// analog and partial networking flags, asynchronous
	input wire i_supply_low,
	input wire i_pn_osc_ok,
	input wire i_frame_detect_error,
	input wire i_tx_timeout,
	// chip mode controller, same clock
	input wire [1:0] i_chip_mode,
	output wire [1:0] o_xcvr_state,
	output wire o_main_supply_on,
	output wire o_sleep_exit
);

	localparam [1:0] WS_IDLE = 2'h0;
	localparam [1:0] WS_REC = 2'h1;
	localparam [1:0] WS_DOM2 = 2'h2;
	localparam [23:0] DOM_CNT = `CWS_DOM_CYC;
	localparam [23:0] REC_CNT = `CWS_REC_CYC;
	localparam [23:0] WAKE_CNT = WAKE_TO_CYC;
	localparam [23:0] SIL_CNT = SILENCE_CYC;
	localparam PN_ON = (PN_BUILD != 0);

	// two-stage synchronisers for all asynchronous inputs
	reg [5:0] sync1_reg;
	reg [5:0] sync2_reg;
	wire bus_s = sync2_reg[0];
	wire txd_s = sync2_reg[1];
	wire suplow_s = sync2_reg[2];
	wire osc_s = sync2_reg[3];
	wire fde_s = sync2_reg[4];
	wire txto_s = sync2_reg[5];

	always @(posedge i_clock) begin
		if (!i_resetn) begin
			sync1_reg <= 6'h3F;
			sync2_reg <= 6'h3F;
		end else begin
			sync1_reg <= {i_tx_timeout, i_frame_detect_error, i_pn_osc_ok,
				i_supply_low, i_txd, i_bus_rx};
			sync2_reg <= sync1_reg;
		end
	end

	// registers
	reg [7:0] ctrl_reg;
	reg wake_en_reg;
	reg wake_evt_reg;
	reg main_sup_reg;
	reg exit_reg;

	wire fd_en = ctrl_reg[`CWS_CTRL_FD_BIT];
	wire cfg_valid = ctrl_reg[`CWS_CTRL_VALID_BIT];
	wire selw_en = ctrl_reg[`CWS_CTRL_SELW_BIT];
	wire [1:0] mode_sel = ctrl_reg[1:0];

	// bus silence timer
	reg bus_prev_reg;
	reg [23:0] sil_cnt_reg;
	wire bus_edge = bus_s ^ bus_prev_reg;
	wire silent = (sil_cnt_reg >= SIL_CNT);

	always @(posedge i_clock) begin
		if (!i_resetn) begin
			bus_prev_reg <= 1'b1;
			sil_cnt_reg <= 24'h000000;
		end else begin
			bus_prev_reg <= bus_s;
			if (bus_edge)
				sil_cnt_reg <= 24'h000000;
			else if (!silent)
				sil_cnt_reg <= sil_cnt_reg + 24'h000001;
		end
	end

	// transceiver state
	reg lock_reg;
	reg [1:0] xs_next;
	wire normal = (i_chip_mode == `CWS_CHIP_NORMAL);
	wire act_req = normal && (mode_sel == `CWS_SEL_ACT_UV ||
		mode_sel == `CWS_SEL_ACT_NOUV);
	wire uv_drop = (mode_sel == `CWS_SEL_ACT_UV) && suplow_s;
	reg [1:0] xs_reg;
	wire is_active = (xs_reg == `CWS_XS_ACTIVE);

	always @* begin
		if (!normal || mode_sel == `CWS_SEL_OFFLINE || (act_req && uv_drop))
			xs_next = silent ? `CWS_XS_OFFLINE : `CWS_XS_OFF_BIAS;
		else if (mode_sel == `CWS_SEL_LISTEN || lock_reg ||
			(act_req && !is_active && !txd_s))
			xs_next = `CWS_XS_LISTEN;
		else
			xs_next = `CWS_XS_ACTIVE;
	end

	always @(posedge i_clock) begin
		if (!i_resetn) begin
			xs_reg <= `CWS_XS_OFFLINE;
			lock_reg <= 1'b0;
		end else begin
			xs_reg <= xs_next;
			// lock set at selection, cleared by txd high
			lock_reg <= act_req && !txd_s && (lock_reg || !is_active);
		end
	end

	// wake filter
	reg [1:0] ws_reg;
	reg [23:0] run_reg;
	reg [23:0] win_reg;
	wire offline = (xs_reg == `CWS_XS_OFFLINE ||
		xs_reg == `CWS_XS_OFF_BIAS);
	wire monitor = offline && wake_en_reg && (!selw_en || !cfg_valid ||
		!PN_ON);
	wire want_rec = (ws_reg == WS_REC);
	wire at_level = (bus_s == want_rec);
	wire [23:0] need = want_rec ? REC_CNT : DOM_CNT;
	// phase completes only after its minimum time
	wire phase_done = at_level && (run_reg + 24'h000001 >= need);
	wire win_out = (ws_reg != WS_IDLE) && (win_reg >= WAKE_CNT);
	wire wake_hit = monitor && !win_out && (ws_reg == WS_DOM2) && phase_done;

	always @(posedge i_clock) begin
		if (!i_resetn) begin
			ws_reg <= WS_IDLE;
			run_reg <= 24'h000000;
			win_reg <= 24'h000000;
		end else if (!monitor || win_out) begin
			ws_reg <= WS_IDLE;
			run_reg <= 24'h000000;
			win_reg <= 24'h000000;
		end else begin
			if (ws_reg != WS_IDLE)
				win_reg <= win_reg + 24'h000001;
			// a short opposite pulse restarts the phase, not the sequence
			if (!at_level || phase_done)
				run_reg <= 24'h000000;
			else
				run_reg <= run_reg + 24'h000001;
			case (ws_reg)
			WS_IDLE: begin
				// first dominant phase opens the window
				if (phase_done) begin
					ws_reg <= WS_REC;
					win_reg <= 24'h000000;
				end
			end
			WS_REC: begin
				if (phase_done)
					ws_reg <= WS_DOM2;
			end
			WS_DOM2: begin
				if (phase_done)
					ws_reg <= WS_IDLE;
			end
			default: begin
				ws_reg <= WS_IDLE;
			end
			endcase
		end
	end

	// axi write channel
	reg aw_full_reg;
	reg w_full_reg;
	reg [7:0] aw_idx_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;
	wire aw_take = i_s_axi_awvalid && !aw_full_reg && !bvalid_reg;
	wire w_take = i_s_axi_wvalid && !w_full_reg && !bvalid_reg;
	wire wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
	wire wr_lane0 = wr_go && wstrb_reg[0];
	wire wr_ctrl = wr_lane0 && (aw_idx_reg == `CWS_IDX_MODE_CTRL);
	wire wr_evt = wr_lane0 && (aw_idx_reg == `CWS_IDX_WAKE_EVT);
	wire wr_cfg = wr_lane0 && (aw_idx_reg == `CWS_IDX_WAKE_CFG);
	wire wr_map = (aw_idx_reg == `CWS_IDX_MODE_CTRL) ||
		(aw_idx_reg == `CWS_IDX_XCVR_COND) ||
		(aw_idx_reg == `CWS_IDX_WAKE_EVT) ||
		(aw_idx_reg == `CWS_IDX_WAKE_CFG);
	// partial networking control bits are reserved without that build
	wire [7:0] ctrl_mask = PN_ON ? `CWS_CTRL_WMASK : 8'h83;

	assign o_s_axi_awready = !aw_full_reg && !bvalid_reg;
	assign o_s_axi_wready = !w_full_reg && !bvalid_reg;
	assign o_s_axi_bvalid = bvalid_reg;
	assign o_s_axi_bresp = bresp_reg;

	always @(posedge i_clock) begin
		if (!i_resetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_idx_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `CWS_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_full_reg <= 1'b1;
				aw_idx_reg <= i_s_axi_awaddr[9:2];
			end
			if (w_take) begin
				w_full_reg <= 1'b1;
				wdata_reg <= i_s_axi_wdata;
				wstrb_reg <= i_s_axi_wstrb;
			end
			if (wr_go) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_map ? `CWS_RESP_OKAY : `CWS_RESP_SLVERR;
			end else if (bvalid_reg && i_s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// control registers and wake event
	wire evt_clr = wr_evt && wdata_reg[`CWS_EVT_WAKE_BIT];
	wire sleeping = (i_chip_mode == `CWS_CHIP_SLEEP);
	reg sleep_prev_reg;

	always @(posedge i_clock) begin
		if (!i_resetn) begin
			ctrl_reg <= `CWS_CTRL_RESET;
			wake_en_reg <= 1'b0;
			wake_evt_reg <= 1'b0;
			main_sup_reg <= 1'b1;
			exit_reg <= 1'b0;
			sleep_prev_reg <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= wdata_reg[7:0] & ctrl_mask;
			if (wr_cfg)
				wake_en_reg <= wdata_reg[`CWS_CFG_WAKE_EN_BIT];
			if (wake_hit)
				wake_evt_reg <= 1'b1;
			else if (evt_clr)
				wake_evt_reg <= 1'b0;
			sleep_prev_reg <= sleeping;
			// wake from sleep restores the supply and asks for reset
			exit_reg <= wake_hit && sleeping;
			if (wake_hit && sleeping)
				main_sup_reg <= 1'b1;
			else if (sleeping && !sleep_prev_reg)
				main_sup_reg <= 1'b0;
		end
	end

	// condition register
	wire [7:0] cond;
	assign cond[`CWS_COND_ACTIVE_BIT] = is_active;
	assign cond[`CWS_COND_PNERR_BIT] = PN_ON && (fde_s || !cfg_valid);
	assign cond[`CWS_COND_PNCFG_BIT] = PN_ON && cfg_valid;
	assign cond[`CWS_COND_OSC_BIT] = PN_ON && osc_s;
	assign cond[`CWS_COND_SILENT_BIT] = silent;
	assign cond[2] = 1'b0;
	// supply indication only with undervoltage mode
	assign cond[`CWS_COND_SUPLOW_BIT] = (mode_sel == `CWS_SEL_ACT_UV) &&
		suplow_s;
	assign cond[`CWS_COND_TXTO_BIT] = txto_s;

	// axi read channel
	reg rvalid_reg;
	reg [31:0] rdata_reg;
	reg [1:0] rresp_reg;
	reg [7:0] rd_val;
	reg rd_ok;
	wire ar_take = i_s_axi_arvalid && !rvalid_reg;

	always @* begin
		rd_ok = 1'b1;
		case (i_s_axi_araddr[9:2])
		`CWS_IDX_MODE_CTRL: rd_val = ctrl_reg;
		`CWS_IDX_XCVR_COND: rd_val = cond;
		`CWS_IDX_WAKE_EVT: rd_val = {7'h00, wake_evt_reg};
		`CWS_IDX_WAKE_CFG: rd_val = {7'h00, wake_en_reg};
		default: begin
			rd_val = 8'h00;
			rd_ok = 1'b0;
		end
		endcase
	end

	assign o_s_axi_arready = !rvalid_reg;
	assign o_s_axi_rvalid = rvalid_reg;
	assign o_s_axi_rdata = rdata_reg;
	assign o_s_axi_rresp = rresp_reg;

	always @(posedge i_clock) begin
		if (!i_resetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `CWS_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= {24'h000000, rd_val};
			rresp_reg <= rd_ok ? `CWS_RESP_OKAY : `CWS_RESP_SLVERR;
		end else if (rvalid_reg && i_s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// pin outputs
	reg rxd_reg;
	always @(posedge i_clock) begin
		if (!i_resetn)
			rxd_reg <= 1'b1;
		// rxd held low while a wake event is pending
		else
			rxd_reg <= !(wake_evt_reg || wake_hit) &&
				(offline ? 1'b1 : bus_s);
	end

	assign o_rxd = rxd_reg;
	assign o_tx_enable = is_active;
	assign o_bias_on = (xs_reg != `CWS_XS_OFFLINE);
	assign o_xcvr_state = xs_reg;
	assign o_main_supply_on = main_sup_reg;
	assign o_sleep_exit = exit_reg;

endmodule
`default_nettype wire

// ===== tb/cws_wake_status_checker.sv
// assertions on the ports of the wake and status block
// assumes it is bound to every instance of cws_wake_status
`timescale 1ns/100ps
`default_nettype none
`include "cws_defines.vh"
module cws_wake_status_checker (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// watched ports
	input wire logic [1:0] i_chip_mode,
	input wire logic [1:0] o_xcvr_state,
	input wire logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	input wire logic [31:0] o_s_axi_rdata,
	input wire logic o_tx_enable,
	input wire logic o_bias_on,
	input wire logic o_sleep_exit,
	input wire logic o_main_supply_on
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	upper_zero_a:
		assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	rdata_hold_a:
		assert property (o_s_axi_rvalid |=>
			$past(i_s_axi_rready) != o_s_axi_rvalid) else $error("read lost");
	bresp_hold_a:
		assert property (o_s_axi_bvalid |=>
			$past(i_s_axi_bready) != o_s_axi_bvalid)
		else $error("write response dropped");
	tx_active_a:
		assert property (o_tx_enable == (o_xcvr_state == `CWS_XS_ACTIVE))
		else $error("transmitter enable not tied to active");
	bias_state_a:
		assert property (o_bias_on == (o_xcvr_state != `CWS_XS_OFFLINE))
		else $error("bias out of step with state");
	forced_off_a:
		assert property (i_chip_mode != `CWS_CHIP_NORMAL |=> o_xcvr_state
			inside {`CWS_XS_OFFLINE, `CWS_XS_OFF_BIAS}) else $error("not offline");
	active_normal_a:
		assert property (o_xcvr_state == `CWS_XS_ACTIVE |->
			$past(i_chip_mode) == `CWS_CHIP_NORMAL) else $error("active off normal");
	exit_pulse_a:
		assert property (o_sleep_exit |=> !o_sleep_exit)
		else $error("sleep exit longer than one cycle");
	exit_supply_a:
		assert property (o_sleep_exit |-> ##[0:2] o_main_supply_on)
		else $error("main supply not on after wake");
	cover property (o_sleep_exit);
	cover property (o_xcvr_state == `CWS_XS_ACTIVE);
	cover property (o_s_axi_rvalid && i_s_axi_rready);
endmodule
bind cws_wake_status cws_wake_status_checker i_chk (.i_clock, .i_resetn,
	.i_chip_mode, .o_xcvr_state, .o_s_axi_bvalid, .i_s_axi_bready,
	.o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata, .o_tx_enable,
	.o_bias_on, .o_sleep_exit, .o_main_supply_on);
`default_nettype wire

// ===== tb/cws_bus_node.sv
// remote bus node driving the receive level seen by the block
// assumes the bus rests recessive, held there by its termination
`timescale 1ns/100ps
`default_nettype none
module cws_bus_node (
	input wire logic i_clock,
	output var logic o_bus_rx
);
	initial o_bus_rx = 1'b1;
	task automatic phase(input logic lvl, input int n);
		o_bus_rx <= lvl;
		repeat (n) @(posedge i_clock);
	endtask
	// dominant, recessive with optional glitch, dominant
	task automatic pattern(input int d, input int r, input int g);
		phase(1'b0, d);
		if (g > 0) begin
			phase(1'b1, r / 2);
			phase(1'b0, g);
		end
		phase(1'b1, r);
		phase(1'b0, d);
		phase(1'b1, 1);
	endtask
endmodule
`default_nettype wire

// ===== tb/tb_cws_wake_status.sv
// self-checking bench for the wake and status block
// assumes short wake window and silence counts set by parameter here
`timescale 1ns/100ps
`default_nettype none
`include "cws_defines.vh"
module tb_cws_wake_status;
	logic i_clock, i_resetn, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
	logic i_s_axi_arvalid, i_s_axi_rready, i_txd, i_supply_low, i_pn_osc_ok;
	logic i_frame_detect_error, i_tx_timeout;
	logic [31:0] i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_araddr, seed, d;
	logic [3:0] i_s_axi_wstrb;
	logic [2:0] i_s_axi_awprot, i_s_axi_arprot;
	logic [1:0] i_chip_mode, r;
	wire [31:0] o_s_axi_rdata;
	wire [1:0] o_s_axi_bresp, o_s_axi_rresp, o_xcvr_state;
	wire o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
	wire o_s_axi_rvalid, o_rxd, o_tx_enable, o_bias_on, o_main_supply_on;
	wire o_sleep_exit, i_bus_rx;
	int err_count, checks, n_exit, i, k;
	int m_reg[int];
	cws_bus_node i_node (.i_clock, .o_bus_rx(i_bus_rx));
	cws_wake_status #(.PN_BUILD(1), .WAKE_TO_CYC(2000), .SILENCE_CYC(500))
	i_cws_wake_status (.i_clock, .i_resetn, .i_s_axi_awaddr, .i_s_axi_awprot,
		.i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb,
		.i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid,
		.i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arprot, .i_s_axi_arvalid,
		.o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid,
		.i_s_axi_rready, .i_bus_rx, .i_txd, .o_rxd, .o_tx_enable, .o_bias_on,
		.i_supply_low, .i_pn_osc_ok, .i_frame_detect_error, .i_tx_timeout,
		.i_chip_mode, .o_xcvr_state, .o_main_supply_on, .o_sleep_exit);
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// condition register as the rules describe it; bus idle so silent
	function automatic logic [31:0] cond(input logic [7:0] c);
		logic act;
		act = (c[1:0] == 2'h2) || (c[1:0] == 2'h1 && !i_supply_low);
		return {24'h0, act, i_frame_detect_error | !c[5], c[5], i_pn_osc_ok,
			2'h2, i_supply_low && c[1:0] == 2'h1, i_tx_timeout};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// ready is looked at before the edge so no race with the slave
	task automatic wr(input logic [31:0] a, input logic [31:0] v,
		input logic [3:0] s, output logic [1:0] rs);
		logic aw, w, ta, tw, b;
		@(posedge i_clock);
		aw = 1'b1;
		w = 1'b1;
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= v;
		i_s_axi_wstrb <= s;
		i_s_axi_awvalid <= 1'b1;
		i_s_axi_wvalid <= 1'b1;
		i_s_axi_bready <= 1'b1;
		do begin
			@(negedge i_clock);
			ta = aw & o_s_axi_awready;
			tw = w & o_s_axi_wready;
			b = o_s_axi_bvalid;
			rs = o_s_axi_bresp;
			@(posedge i_clock);
			if (ta) begin
				aw = 1'b0;
				i_s_axi_awvalid <= 1'b0;
			end
			if (tw) begin
				w = 1'b0;
				i_s_axi_wvalid <= 1'b0;
			end
		end while (!b);
		i_s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] v,
		output logic [1:0] rs);
		logic ar, ta, b;
		@(posedge i_clock);
		ar = 1'b1;
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'b1;
		i_s_axi_rready <= 1'b1;
		do begin
			@(negedge i_clock);
			ta = ar & o_s_axi_arready;
			b = o_s_axi_rvalid;
			v = o_s_axi_rdata;
			rs = o_s_axi_rresp;
			@(posedge i_clock);
			if (ta) begin
				ar = 1'b0;
				i_s_axi_arvalid <= 1'b0;
			end
		end while (!b);
		i_s_axi_rready <= 1'b0;
	endtask
	task automatic close_out();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end
	initial begin
		#400000;
		err_count++;
		close_out();
	end
	always @(posedge i_clock) if (o_sleep_exit === 1'b1) n_exit++;
	initial begin
		{i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid} = 0;
		{i_s_axi_rready, i_supply_low, i_pn_osc_ok, i_tx_timeout} = 0;
		{i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_araddr, i_s_axi_wstrb} = 0;
		{i_s_axi_awprot, i_s_axi_arprot, i_frame_detect_error} = 0;
		i_resetn = 1'b0;
		i_txd = 1'b1;
		i_chip_mode = `CWS_CHIP_NORMAL;
		seed = 32'hB84FB7E7;
		m_reg[32'h80] = 0;
		m_reg[32'h8C] = 0;
		m_reg[32'h90] = 0;
		repeat (10) @(posedge i_clock);
		i_resetn <= 1'b1;
		repeat (600) @(posedge i_clock);
		foreach (m_reg[a]) begin
			rd(a, d, r);
			chk(d, m_reg[a]);
		end
		for (i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			{i_supply_low, i_pn_osc_ok, i_frame_detect_error, i_tx_timeout} <=
				seed[11:8];
			wr(32'h80, seed, 4'hF, r);
			m_reg[32'h80] = seed[7:0] & 8'hF3;
			wr(32'h88, 32'hFF, 4'hF, r);
			chk(r, `CWS_RESP_OKAY);
			repeat (5) @(posedge i_clock);
			rd(32'h80, d, r);
			chk(d, m_reg[32'h80]);
			rd(32'h88, d, r);
			chk(d, cond(seed[7:0] & 8'hF3));
			chk(o_tx_enable, cond(seed[7:0] & 8'hF3) >> 7);
		end
		rd(32'h40, d, r);
		chk(d, 0);
		chk(r, `CWS_RESP_SLVERR);
		wr(32'h44, 1, 4'hF, r);
		chk(r, `CWS_RESP_SLVERR);
		wr(32'h80, 32'hFF, 4'h0, r);
		rd(32'h80, d, r);
		chk(d, m_reg[32'h80]);
		wr(32'h80, 0, 4'hF, r);
		i_txd <= 1'b0;
		repeat (4) @(posedge i_clock);
		wr(32'h80, 2, 4'hF, r);
		repeat (5) @(posedge i_clock);
		rd(32'h88, d, r);
		chk(d[7], 0);
		i_txd <= 1'b1;
		repeat (5) @(posedge i_clock);
		rd(32'h88, d, r);
		chk(d[7], 1);
		wr(32'h90, 1, 4'hF, r);
		i_chip_mode <= `CWS_CHIP_SLEEP;
		repeat (4) @(posedge i_clock);
		chk(o_main_supply_on, 0);
		// short phases, selective wake armed, then a valid pattern
		for (k = 0; k < 3; k++) begin
			wr(32'h80, k == 1 ? 32'h30 : 0, 4'hF, r);
			i_node.pattern(k == 0 ? 100 : 130, k == 0 ? 100 : 130, k == 2 ? 5 : 0);
			repeat (6) @(posedge i_clock);
			chk(o_rxd, k != 2);
			chk(o_main_supply_on, k == 2);
			rd(32'h8C, d, r);
			chk(d, k == 2);
			repeat (2100) @(posedge i_clock);
			chk({o_bias_on, o_xcvr_state}, {1'b0, `CWS_XS_OFFLINE});
		end
		chk(n_exit, 1);
		wr(32'h8C, 1, 4'hF, r);
		rd(32'h8C, d, r);
		chk(d, 0);
		chk(o_rxd, 1);
		close_out();
	end
endmodule
`default_nettype wire
